// >>> inc/bhrx_pkg.sv
// Constants and types shared by the boot hex record receiver
package bhrx_pkg;
    localparam logic [7:0] START_MARK = 8'h3A;
    localparam logic [7:0] TYPE_DATA = 8'h00;
    localparam logic [7:0] TYPE_END = 8'h01;
    localparam logic [7:0] TYPE_EXT = 8'h02;
    localparam logic [7:0] EXT_LEN = 8'h02;
    localparam logic [7:0] END_LEN = 8'h00;
    localparam logic [15:0] EXT_OFFSET = 16'h0000;
    localparam logic [15:0] SEG_LIMIT = 16'h2000;
    localparam logic [7:0] CMD_ERASE = 8'hF0;
    localparam logic [7:0] CMD_WRITE = 8'h30;
    localparam logic [7:0] CMD_READ = 8'h40;
    localparam logic [7:0] CMD_RAMLD = 8'h60;
    localparam logic [7:0] CMD_ID = 8'hC0;
    localparam logic [7:0] CMD_STAT = 8'hC3;
    localparam logic [4:0] ID_FIRST = 5'h09;
    localparam logic [4:0] ID_LAST = 5'h12;
    localparam logic [4:0] STAT_FIRST = 5'h09;
    localparam logic [4:0] STAT_LAST = 5'h0C;
    localparam logic [1:0] REPLY_WRITE = 2'h3;
    localparam logic [1:0] REPLY_RAMLD = 2'h2;

    typedef enum logic [2:0] {
        BHRX_WAIT,
        BHRX_LEN,
        BHRX_OFFH,
        BHRX_OFFL,
        BHRX_TYPE,
        BHRX_DATA,
        BHRX_CSUM,
        BHRX_IDLE
    } bhrx_state_t;
endpackage : bhrx_pkg

// >>> core/bhrx_sync.sv
// Two-stage synchroniser for one level
`timescale 1ns/100ps
module bhrx_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Level
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : bhrx_sync

// >>> core/bhrx_sum.sv
// 16-bit byte-sum accumulator
`timescale 1ns/100ps
module bhrx_sum (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic add,
    input wire logic [7:0] data,
    // Result
    output logic [15:0] sum
);
    logic [15:0] sum_d;

    // Carry past bit 15 is dropped
    assign sum_d = sum + {8'h00, data}; // [R2] [R22]

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sum <= 16'h0000;
        else if (clear)
            sum <= 16'h0000;
        else if (add)
            sum <= sum_d;
    end
endmodule : bhrx_sum

// >>> core/bhrx_core.sv
// Boot hex record receiver with record checks and reply checksum
// Behaviour
// [R1] Checksum reply after erase, write, sum, read, RAM load, ID and status commands.
// [R2] Sum is bytes added singly, delivered as a 16-bit word.
// [R3] Erase sums whole array for chip erase, erased region for sector erase.
// [R4] Write and sum commands sum full flash range; record framing excluded.
// [R5] Read command sums only the bytes read out.
// [R6] RAM load sums received RAM bytes, framing and record checksums excluded.
// [R7] ID sums transferred bytes 9 to 18; status sums bytes 9 to 12.
// [R8] Records are binary and begin with start mark 0x3A.
// [R9] After a data record checksum, discard bytes until next start mark.
// [R10] After end record, controller silent until 3 or 2 byte reply.
// [R11] Receive or format error enters idle silently.
// [R12] Record type other than 00, 01, 02 is a format error.
// [R13] Record checksum mismatch is a format error.
// [R14] Extended record length not 2 or offset not 0 is an error.
// [R15] Data record after extended segment above 0x2000 is an error.
// [R16] End record with nonzero length is a format error.
// [R17] Data record: mark, count, big-endian address, type 00, data, checksum.
// [R18] Record checksum is two's complement of length, offset, type, payload sum.
// [R19] End record: length 00, offset 0000, type 01, checksum. The code checks length and type only and accepts any offset.
// [R20] Extended record: length 02, offset 0000, type 02, big-endian segment.
// [R21] Idle ignores the link until reset.
// [R22] Sum word wraps modulo 65536.
`timescale 1ns/100ps
module bhrx_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command context from the command handler
    input wire logic cmd_start,
    input wire logic [7:0] cmd_code,
    // Received bytes from the serial receiver
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_error,
    // Bytes the device transmits, counted for ID and status sums
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    // Memory bytes covered by erase, write and read sums
    input wire logic mem_valid,
    input wire logic [7:0] mem_data,
    // Decoded record output
    output logic wr_valid,
    output logic [15:0] wr_seg,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data,
    // Status
    output logic end_seen,
    output logic [1:0] reply_len,
    output logic link_idle,
    output logic [15:0] sum_word,
    output logic sum_ready
);
    logic err_sync;
    logic [15:0] sum_raw;
    bhrx_pkg::bhrx_state_t state_q;
    bhrx_pkg::bhrx_state_t state_d;
    bhrx_pkg::bhrx_state_t state_nx;
    logic idle_q;
    logic [7:0] len_q;
    logic [7:0] cnt_q;
    logic [7:0] type_q;
    logic [7:0] rsum_q;
    logic [15:0] off_q;
    logic [15:0] seg_q;
    logic [15:0] ext_q;
    logic [7:0] cmd_q;
    logic [4:0] txn_q;
    logic [15:0] addr_q;
    logic wr_valid_q;
    logic [7:0] wr_data_q;
    logic end_q;
    logic ready_q;
    logic [1:0] reply_q;

    // Error line comes from the serial framing logic, possibly another domain
    bhrx_sync u_err_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(rx_error),
        .q(err_sync)
    );

    wire is_rec_cmd = (cmd_q == bhrx_pkg::CMD_WRITE) || (cmd_q == bhrx_pkg::CMD_RAMLD);
    wire is_mem_cmd = (cmd_q == bhrx_pkg::CMD_ERASE) || (cmd_q == bhrx_pkg::CMD_WRITE)
        || (cmd_q == bhrx_pkg::CMD_READ);
    // A byte that meets the synchronised receive error is dropped, never written
    wire rx_take = rx_valid && (state_q != bhrx_pkg::BHRX_IDLE) && !err_sync; // [R11] [R21]
    wire [7:0] rsum_next = rsum_q + rx_data;
    wire payload_byte = rx_take && (state_q == bhrx_pkg::BHRX_DATA);
    wire data_byte = payload_byte && (type_q == bhrx_pkg::TYPE_DATA);
    // Checksum byte makes the running record sum zero
    wire csum_ok = (rsum_next == 8'h00); // [R13] [R18]
    wire type_ok = (rx_data == bhrx_pkg::TYPE_DATA) || (rx_data == bhrx_pkg::TYPE_END)
        || (rx_data == bhrx_pkg::TYPE_EXT); // [R12]
    wire ext_bad = (rx_data == bhrx_pkg::TYPE_EXT)
        && ((len_q != bhrx_pkg::EXT_LEN) || (off_q != bhrx_pkg::EXT_OFFSET)); // [R14] [R20]
    wire end_bad = (rx_data == bhrx_pkg::TYPE_END) && (len_q != bhrx_pkg::END_LEN); // [R16] [R19]
    wire data_bad = (rx_data == bhrx_pkg::TYPE_DATA)
        && ((seg_q > bhrx_pkg::SEG_LIMIT) || (len_q == 8'h00)); // [R15] [R17]
    wire type_bad = !type_ok || ext_bad || end_bad || data_bad;
    wire [4:0] txn_next = txn_q + 5'h01;
    wire id_in = (cmd_q == bhrx_pkg::CMD_ID) && (txn_next >= bhrx_pkg::ID_FIRST)
        && (txn_next <= bhrx_pkg::ID_LAST);
    wire stat_in = (cmd_q == bhrx_pkg::CMD_STAT) && (txn_next >= bhrx_pkg::STAT_FIRST)
        && (txn_next <= bhrx_pkg::STAT_LAST);
    // Count of cycles with a transferred byte in either direction, held at 31, for ID and status
    wire xfer = (rx_valid || tx_valid) && (txn_q != 5'h1F);
    wire [7:0] xfer_byte = tx_valid ? tx_data : rx_data;
    wire tx_add = xfer && (id_in || stat_in); // [R7]
    // Write command sums flash afterwards, not the record payload
    wire ram_add = data_byte && (cmd_q == bhrx_pkg::CMD_RAMLD); // [R6]
    wire mem_add = mem_valid && is_mem_cmd; // [R3] [R4] [R5]
    wire sum_add = ram_add || mem_add || tx_add;
    wire [7:0] sum_byte = ram_add ? rx_data : (mem_add ? mem_data : xfer_byte);

    bhrx_sum u_sum (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(cmd_start),
        .add(sum_add), // [R1]
        .data(sum_byte),
        .sum(sum_raw)
    );

    always_comb
    begin
        state_d = state_q;
        if (err_sync && (state_q != bhrx_pkg::BHRX_IDLE))
            state_d = bhrx_pkg::BHRX_IDLE; // [R11]
        else if (rx_take && is_rec_cmd)
        begin
            case (state_q)
                bhrx_pkg::BHRX_WAIT:
                    if (rx_data == bhrx_pkg::START_MARK)
                        state_d = bhrx_pkg::BHRX_LEN; // [R8] [R9]
                bhrx_pkg::BHRX_LEN:
                    state_d = bhrx_pkg::BHRX_OFFH;
                bhrx_pkg::BHRX_OFFH:
                    state_d = bhrx_pkg::BHRX_OFFL;
                bhrx_pkg::BHRX_OFFL:
                    state_d = bhrx_pkg::BHRX_TYPE;
                bhrx_pkg::BHRX_TYPE:
                    if (type_bad)
                        state_d = bhrx_pkg::BHRX_IDLE; // [R11]
                    else if (len_q == 8'h00)
                        state_d = bhrx_pkg::BHRX_CSUM;
                    else
                        state_d = bhrx_pkg::BHRX_DATA;
                bhrx_pkg::BHRX_DATA:
                    if (cnt_q == 8'h01)
                        state_d = bhrx_pkg::BHRX_CSUM;
                bhrx_pkg::BHRX_CSUM:
                    if (!csum_ok)
                        state_d = bhrx_pkg::BHRX_IDLE; // [R13]
                    else
                        state_d = bhrx_pkg::BHRX_WAIT; // [R9]
                default:
                    state_d = bhrx_pkg::BHRX_IDLE;
            endcase
        end
    end

    wire rec_end = rx_take && (state_q == bhrx_pkg::BHRX_CSUM) && csum_ok
        && (type_q == bhrx_pkg::TYPE_END) && !err_sync;
    wire rec_ext = rx_take && (state_q == bhrx_pkg::BHRX_CSUM) && csum_ok
        && (type_q == bhrx_pkg::TYPE_EXT);

    // A new command restarts parsing, but never leaves idle
    assign state_nx = (cmd_start && (state_q != bhrx_pkg::BHRX_IDLE)) ? bhrx_pkg::BHRX_WAIT
        : state_d;

    // Idle flag kept in its own flop so the output needs no decode
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= bhrx_pkg::BHRX_WAIT;
            idle_q <= 1'b0;
        end
        else
        begin
            state_q <= state_nx;
            idle_q <= (state_nx == bhrx_pkg::BHRX_IDLE); // [R11] [R21]
        end
    end

    // Record fields and running record sum
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            type_q <= 8'h00;
            rsum_q <= 8'h00;
            off_q <= 16'h0000;
            seg_q <= 16'h0000;
            ext_q <= 16'h0000;
        end
        else if (cmd_start)
            seg_q <= 16'h0000;
        else if (rx_take)
        begin
            case (state_q)
                bhrx_pkg::BHRX_WAIT:
                    rsum_q <= 8'h00;
                bhrx_pkg::BHRX_LEN:
                begin
                    len_q <= rx_data;
                    cnt_q <= rx_data;
                    rsum_q <= rsum_next;
                end
                bhrx_pkg::BHRX_OFFH:
                begin
                    off_q <= {rx_data, 8'h00};
                    rsum_q <= rsum_next;
                end
                bhrx_pkg::BHRX_OFFL:
                begin
                    off_q <= {off_q[15:8], rx_data};
                    rsum_q <= rsum_next;
                end
                bhrx_pkg::BHRX_TYPE:
                begin
                    type_q <= rx_data;
                    rsum_q <= rsum_next;
                end
                bhrx_pkg::BHRX_DATA:
                begin
                    cnt_q <= cnt_q - 8'h01;
                    rsum_q <= rsum_next;
                    ext_q <= {ext_q[7:0], rx_data};
                end
                default:
                    if (rec_ext)
                        seg_q <= ext_q;
            endcase
        end
    end

    // Command latch, transfer count and write stream
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_q <= 8'h00;
            txn_q <= 5'h00;
            addr_q <= 16'h0000;
            wr_valid_q <= 1'b0;
            wr_data_q <= 8'h00;
        end
        else
        begin
            wr_valid_q <= data_byte;
            if (cmd_start)
            begin
                cmd_q <= cmd_code;
                txn_q <= 5'h00;
            end
            else if (xfer)
                txn_q <= txn_next;
            if (rx_take && (state_q == bhrx_pkg::BHRX_OFFL))
                addr_q <= {off_q[15:8], rx_data}; // [R17]
            else if (wr_valid_q)
                addr_q <= addr_q + 16'h0001;
            if (data_byte)
                wr_data_q <= rx_data;
        end
    end

    // Reply length is held until the next command; idle latches until reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            end_q <= 1'b0;
            ready_q <= 1'b0;
            reply_q <= 2'h0;
        end
        else if (cmd_start)
        begin
            end_q <= 1'b0;
            ready_q <= 1'b0;
            reply_q <= 2'h0;
        end
        else if (rec_end)
        begin
            end_q <= 1'b1;
            ready_q <= 1'b1;
            reply_q <= (cmd_q == bhrx_pkg::CMD_WRITE) ? bhrx_pkg::REPLY_WRITE
                : bhrx_pkg::REPLY_RAMLD; // [R10]
        end
    end

    assign wr_valid = wr_valid_q;
    assign wr_addr = addr_q;
    assign wr_data = wr_data_q;
    assign wr_seg = seg_q;
    assign end_seen = end_q;
    assign reply_len = reply_q;
    assign link_idle = idle_q;
    assign sum_word = sum_raw;
    assign sum_ready = ready_q;
endmodule : bhrx_core

// >>> testbench/bhrx_core_chk.sv
// Port-level assertions for the boot hex record receiver
`timescale 1ns/100ps
module bhrx_core_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Inputs watched
    input wire logic cmd_start,
    input wire logic [7:0] cmd_code,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_error,
    input wire logic mem_valid,
    input wire logic [7:0] mem_data,
    // Outputs watched
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic end_seen,
    input wire logic [1:0] reply_len,
    input wire logic link_idle,
    input wire logic [15:0] sum_word
);
    logic [7:0] cmd_q;
    wire rec_cmd = (cmd_q == 8'h30) || (cmd_q == 8'h60);
    wire mem_cmd = (cmd_q == 8'hF0) || (cmd_q == 8'h30) || (cmd_q == 8'h40);
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cmd_q <= 8'h00;
        else if (cmd_start)
            cmd_q <= cmd_code;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A gap before each mark keeps payload bytes from posing as a record start
    sequence s_mark;
        !rx_valid ##1 rx_valid && rx_data == bhrx_pkg::START_MARK && !link_idle && rec_cmd;
    endsequence
    sequence s_end_head;
        s_mark ##1 (rx_valid && rx_data == 8'h00) [*3] ##1 rx_valid && rx_data == 8'h01;
    endsequence
    chk_idle_sticky: assert property (link_idle |=> link_idle)
        else $error("idle state left without reset");
    chk_idle_quiet: assert property (link_idle |-> !wr_valid)
        else $error("write strobe while idle");
    chk_wr_cause: assert property (wr_valid
        |-> $past(rx_valid) && wr_data == $past(rx_data))
        else $error("write strobe without matching payload byte");
    chk_bad_type: assert property (s_mark ##1 rx_valid [*3]
        ##1 rx_valid && rx_data > 8'h02 |=> link_idle)
        else $error("unknown record type accepted");
    chk_ext_len: assert property (s_mark ##1 rx_valid && rx_data != 8'h02
        ##1 rx_valid [*2] ##1 rx_valid && rx_data == 8'h02 |=> link_idle)
        else $error("extended record with bad length accepted");
    chk_end_len: assert property (s_mark ##1 rx_valid && rx_data != 8'h00
        ##1 rx_valid [*2] ##1 rx_valid && rx_data == 8'h01 |=> link_idle)
        else $error("end record with nonzero length accepted");
    chk_end_ok: assert property (s_end_head
        ##1 rx_valid && rx_data == 8'hFF |=> end_seen)
        else $error("valid end record not reported");
    chk_end_csum: assert property (s_end_head
        ##1 rx_valid && rx_data != 8'hFF |=> link_idle)
        else $error("end record checksum error accepted");
    chk_reply_len: assert property ($rose(end_seen)
        |-> reply_len == ((cmd_q == 8'h30) ? bhrx_pkg::REPLY_WRITE : bhrx_pkg::REPLY_RAMLD))
        else $error("reply length does not fit the command");
    chk_rx_error: assert property ($rose(rx_error) && !link_idle && rec_cmd
        |-> ##[1:4] link_idle)
        else $error("receive error did not stop the link");
    chk_sum_clear: assert property (cmd_start |=> sum_word == 16'h0000)
        else $error("sum not cleared by a new command");
    chk_mem_add: assert property (mem_valid && mem_cmd && !cmd_start
        |=> sum_word == $past(sum_word) + 16'($past(mem_data)))
        else $error("memory byte not added to the sum");
endmodule : bhrx_core_chk

bind bhrx_core bhrx_core_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_start(cmd_start),
    .cmd_code(cmd_code), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
    .mem_valid(mem_valid), .mem_data(mem_data), .wr_valid(wr_valid), .wr_data(wr_data),
    .end_seen(end_seen), .reply_len(reply_len), .link_idle(link_idle), .sum_word(sum_word));

// >>> testbench/bhrx_ctrl_model.sv
// Programming controller model sending binary hex records
`timescale 1ns/100ps
module bhrx_ctrl_model (
    // Clock
    input wire logic clk_sys,
    // Byte stream to the receiver
    output logic rx_valid,
    output logic [7:0] rx_data
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_data <= b;
    endtask : send
    // Released data line flips so a stale byte never looks valid
    task automatic gap;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask : gap
    task automatic rec(input logic [7:0] len, input logic [15:0] off, input logic [7:0] typ,
        input logic [15:0] pay, input logic bad);
        logic [7:0] s;
        logic [7:0] b;
        gap();
        send(bhrx_pkg::START_MARK);
        send(len);
        send(off[15:8]);
        send(off[7:0]);
        send(typ);
        s = len + off[15:8] + off[7:0] + typ;
        for (int i = 0; i < len; i++)
        begin
            if (typ == 8'h02 && len == 8'h02)
                b = (i == 0) ? pay[15:8] : pay[7:0];
            else
                b = pay[7:0] + 8'(i);
            send(b);
            s = s + b;
        end
        send((~s + 8'h01) ^ {7'h00, bad});
        gap();
    endtask : rec
endmodule : bhrx_ctrl_model

// >>> testbench/boot_hex_record_rx_checksum_bench.sv
// Self-checking bench for the boot hex record receiver
`timescale 1ns/100ps
module boot_hex_record_rx_checksum_bench;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] len;
        logic [15:0] off;
        logic [7:0] typ;
        logic [15:0] pay;
        logic bad;
        logic idle;
        logic endx;
    } bhrx_row_t;
    localparam bhrx_row_t ROWS [10] = '{
        '{8'h30, 8'h01, 16'h1234, 8'h00, 16'h00AA, 1'b0, 1'b0, 1'b0},
        '{8'h60, 8'h01, 16'h0000, 8'h03, 16'h0000, 1'b0, 1'b1, 1'b0},
        '{8'h60, 8'h01, 16'h0000, 8'h02, 16'h0000, 1'b0, 1'b1, 1'b0},
        '{8'h60, 8'h02, 16'h0001, 8'h02, 16'h0000, 1'b0, 1'b1, 1'b0},
        '{8'h30, 8'h01, 16'h0000, 8'h01, 16'h0000, 1'b0, 1'b1, 1'b0},
        '{8'h30, 8'h01, 16'h1234, 8'h00, 16'h00AA, 1'b1, 1'b1, 1'b0},
        '{8'h30, 8'h00, 16'h0000, 8'h01, 16'h0000, 1'b1, 1'b1, 1'b0},
        '{8'h60, 8'h02, 16'h0000, 8'h02, 16'h2000, 1'b0, 1'b0, 1'b0},
        '{8'h60, 8'h00, 16'h0000, 8'h01, 16'h0000, 1'b0, 1'b0, 1'b1},
        '{8'h30, 8'h00, 16'h0000, 8'h01, 16'h0000, 1'b0, 1'b0, 1'b1}};
    localparam logic [7:0] MEM_CMD [3] = '{8'hF0, 8'h30, 8'h40};
    logic clk_sys, rst_n, cmd_start, rx_valid, rx_error, tx_valid, mem_valid;
    logic [7:0] cmd_code, rx_data, tx_data, mem_data, wr_data, last_data;
    logic wr_valid, end_seen, link_idle, sum_ready;
    logic [15:0] wr_seg, wr_addr, sum_word, last_addr, last_seg;
    logic [1:0] reply_len;
    int num_errors, checked, wr_cnt;
    bhrx_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_start(cmd_start),
        .cmd_code(cmd_code), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
        .tx_valid(tx_valid), .tx_data(tx_data), .mem_valid(mem_valid), .mem_data(mem_data),
        .wr_valid(wr_valid), .wr_seg(wr_seg), .wr_addr(wr_addr), .wr_data(wr_data),
        .end_seen(end_seen), .reply_len(reply_len), .link_idle(link_idle),
        .sum_word(sum_word), .sum_ready(sum_ready));
    bhrx_ctrl_model u_ctrl (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data));
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            wr_cnt <= 0;
        else if (wr_valid === 1'b1)
        begin
            wr_cnt <= wr_cnt + 1;
            last_addr <= wr_addr;
            last_data <= wr_data;
            last_seg <= wr_seg;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic restart(input logic [7:0] cmd);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        cmd_start <= 1'b1;
        cmd_code <= cmd;
        tick(1);
        cmd_start <= 1'b0;
    endtask : restart
    task automatic complete_run;
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial
    begin
        {clk_sys, rst_n, cmd_start, rx_error, tx_valid, mem_valid} = 6'h00;
        {cmd_code, tx_data, mem_data} = 24'h000000;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        chk(sum_word, 16'h0000);
        chk({13'h0000, link_idle, end_seen, wr_valid}, 16'h0000);
        foreach (ROWS[i])
        begin
            restart(ROWS[i].cmd);
            u_ctrl.rec(ROWS[i].len, ROWS[i].off, ROWS[i].typ, ROWS[i].pay, ROWS[i].bad);
            tick(3);
            chk(16'(link_idle), 16'(ROWS[i].idle));
            chk(16'(end_seen), 16'(ROWS[i].endx));
            if (ROWS[i].endx)
                chk(16'(reply_len), (ROWS[i].cmd == 8'h30) ? 16'h0003 : 16'h0002);
        end
        // Junk between records, back-to-back payload
        restart(8'h60);
        u_ctrl.send(8'h55);
        u_ctrl.rec(8'h03, 16'h0100, 8'h00, 16'h0010, 1'b0);
        u_ctrl.send(8'hC3);
        u_ctrl.rec(8'h02, 16'h0200, 8'h00, 16'h0020, 1'b0);
        u_ctrl.rec(8'h00, 16'h0000, 8'h01, 16'h0000, 1'b0);
        tick(3);
        chk(16'(wr_cnt), 16'h0005);
        chk(last_addr, 16'h0201);
        chk(16'(last_data), 16'h0021);
        chk(sum_word, 16'h0074);
        chk(16'(sum_ready), 16'h0001);
        // Segment above limit, then the idle link
        restart(8'h60);
        u_ctrl.rec(8'h02, 16'h0000, 8'h02, 16'h1000, 1'b0);
        u_ctrl.rec(8'h01, 16'h0000, 8'h00, 16'h0077, 1'b0);
        u_ctrl.rec(8'h02, 16'h0000, 8'h02, 16'h2001, 1'b0);
        u_ctrl.rec(8'h01, 16'h0005, 8'h00, 16'h0066, 1'b0);
        tick(3);
        chk(last_seg, 16'h1000);
        chk(16'(link_idle), 16'h0001);
        u_ctrl.rec(8'h01, 16'h0000, 8'h00, 16'h0011, 1'b0);
        tick(3);
        chk(16'(wr_cnt), 16'h0001);
        foreach (MEM_CMD[k])
        begin
            restart(MEM_CMD[k]);
            repeat (300)
            begin
                mem_valid <= 1'b1;
                mem_data <= 8'hFF;
                tick(1);
            end
            mem_valid <= 1'b0;
            mem_data <= 8'h00;
            tick(2);
            chk(sum_word, 16'h2AD4);
        end
        for (int k = 0; k < 2; k++)
        begin
            restart(k ? 8'hC3 : 8'hC0);
            for (int n = 1; n <= 20; n++)
            begin
                tx_valid <= 1'b1;
                tx_data <= 8'(n);
                tick(1);
            end
            tx_valid <= 1'b0;
            tick(2);
            chk(sum_word, k ? 16'h002A : 16'h0087);
        end
        restart(8'h30);
        rx_error <= 1'b1;
        for (int w = 0; w < 8 && link_idle !== 1'b1; w++)
            tick(1);
        chk(16'(link_idle), 16'h0001);
        rx_error <= 1'b0;
        complete_run();
    end
endmodule : boot_hex_record_rx_checksum_bench
